// ---- pkg/eeprom_ctrl_pkg.sv ----
/*
  Constants, command codes and frame helpers shared by the serial EEPROM
  command controller and its testbench.
  Assumes a 100 MHz system clock and a byte-wide 3-wire serial EEPROM.
*/
package eeprom_ctrl_pkg;

  // system clock and timeout
  localparam int CLK_PERIOD_NS  = 10;
  localparam int TIMEOUT_MS     = 30;
  localparam int NS_PER_MS      = 1000000;
  localparam int TIMEOUT_CYCLES = TIMEOUT_MS * NS_PER_MS / CLK_PERIOD_NS; // longest time, rounds down

  // field widths
  localparam int CMD_W       = 3;
  localparam int ADDR_W      = 9;
  localparam int DATA_W      = 8;
  localparam int LEAD_W      = 10;
  localparam int LEAD_ADDR_W = 7;
  localparam int FRAME_W     = LEAD_W + DATA_W;
  localparam int CYC_W       = 5;

  // host command codes carried by command_code_field
  localparam logic [CMD_W-1:0] CMD_READ   = 3'h0;
  localparam logic [CMD_W-1:0] CMD_WR_OFF = 3'h1;
  localparam logic [CMD_W-1:0] CMD_WR_ON  = 3'h2;
  localparam logic [CMD_W-1:0] CMD_WRITE  = 3'h3;
  localparam logic [CMD_W-1:0] CMD_FILL   = 3'h4;
  localparam logic [CMD_W-1:0] CMD_ERASE  = 3'h5;
  localparam logic [CMD_W-1:0] CMD_WIPE   = 3'h6;
  localparam logic [CMD_W-1:0] CMD_RELOAD = 3'h7;

  // serial opcodes; the extended group uses the top two address bits
  localparam logic [1:0] OPC_EXT   = 2'h0;
  localparam logic [1:0] OPC_WRITE = 2'h1;
  localparam logic [1:0] OPC_READ  = 2'h2;
  localparam logic [1:0] OPC_ERASE = 2'h3;
  localparam logic [1:0] EXT_WR_OFF = 2'h0;
  localparam logic [1:0] EXT_FILL   = 2'h1;
  localparam logic [1:0] EXT_WIPE   = 2'h2;
  localparam logic [1:0] EXT_WR_ON  = 2'h3;

  // data-in lags the pin by two serial clocks through the three-flop synchroniser
  localparam logic [1:0] SAMPLE_LAG = 2'h2;

  // serial clock counts per frame
  localparam logic [CYC_W-1:0] SHORT_CYCLES = 5'h0A;
  localparam logic [CYC_W-1:0] LONG_CYCLES  = 5'h12;

  // reload check
  localparam logic [DATA_W-1:0] PROGRAMMED_MARK = 8'hA5;
  localparam logic [ADDR_W-1:0] RELOAD_ADDR     = 9'h000;

  // number of serial clocks a command needs
  function automatic logic [CYC_W-1:0] serial_cycles(input logic [CMD_W-1:0] code);
    case (code)
      CMD_READ, CMD_WRITE, CMD_FILL, CMD_RELOAD: serial_cycles = LONG_CYCLES;
      default:                                   serial_cycles = SHORT_CYCLES;
    endcase
  endfunction : serial_cycles

  // commands that end with a ready poll of the memory
  function automatic logic needs_ready(input logic [CMD_W-1:0] code);
    case (code)
      CMD_WRITE, CMD_FILL, CMD_ERASE, CMD_WIPE: needs_ready = 1'b1;
      default:                                  needs_ready = 1'b0;
    endcase
  endfunction : needs_ready

  // start bit, opcode and address part of a frame
  function automatic logic [LEAD_W-1:0] lead_field(input logic [CMD_W-1:0]  code,
                                                   input logic [ADDR_W-1:0] addr);
    logic [LEAD_ADDR_W-1:0] a;
    a = addr[LEAD_ADDR_W-1:0];
    case (code)
      CMD_READ:   lead_field = {1'b1, OPC_READ, a};
      CMD_RELOAD: lead_field = {1'b1, OPC_READ, RELOAD_ADDR[LEAD_ADDR_W-1:0]};
      CMD_WRITE:  lead_field = {1'b1, OPC_WRITE, a};
      CMD_ERASE:  lead_field = {1'b1, OPC_ERASE, a};
      CMD_WR_ON:  lead_field = {1'b1, OPC_EXT, EXT_WR_ON, 5'h00};
      CMD_WR_OFF: lead_field = {1'b1, OPC_EXT, EXT_WR_OFF, 5'h00};
      CMD_WIPE:   lead_field = {1'b1, OPC_EXT, EXT_WIPE, 5'h00};
      CMD_FILL:   lead_field = {1'b1, OPC_EXT, EXT_FILL, 5'h00};
      default:    lead_field = {1'b1, OPC_READ, a};
    endcase
  endfunction : lead_field

endpackage : eeprom_ctrl_pkg

// ---- design/sync_three.sv ----
/*
  Three-flop synchroniser with agreement filter for pins and cross-domain
  signals. Assumes its input is stable for at least two destination edges.
*/
`timescale 1ns/100ps
module sync_three #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic         en,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] ff1_r;
  logic [W-1:0] ff2_r;
  logic [W-1:0] ff3_r;
  logic [W-1:0] q_r;

  // first stage feeds only the second, so metastability stays contained
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ff1_r <= '0;
      ff2_r <= '0;
      ff3_r <= '0;
    end else if (en) begin
      ff1_r <= d;
      ff2_r <= ff1_r;
      ff3_r <= ff2_r;
    end
  end

  // a change counts once stages two and three agree
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      q_r <= '0;
    end else if (en && (ff2_r == ff3_r)) begin
      q_r <= ff3_r;
    end
  end

  assign q = q_r;

endmodule : sync_three

// ---- design/eeprom_cmd_ctrl.sv ----
/*
  Host command controller for a byte-wide 3-wire serial EEPROM: host side on
  clk, serial engine on link_clk, joined by toggle handshakes.
  Assumes the host keeps the command inputs steady while busy.
*/
// Notes on behaviour
// - setting busy starts a command; hardware clears busy at completion
// - read result lands in the data register when busy clears
// - no memory response within 30 ms abandons and sets timeout flag
// - erase clears the one location named by the target field
// - erase-all starts a bulk erase of the whole memory
// - disable command makes the memory ignore later erase and write
// - enable command lets erase and write through until disabled
// - read fetches the addressed location into the data register
// - write stores the data register at the target location
// - write-all stores the data register everywhere; timeout applies
// - 10 serial clocks for short commands, 18 for read and writes
// - reload reads byte zero; anything but A5 fails the reload
// - successful reload sets the data-loaded flag
// - target location carries nine address bits; frames send only the low seven
// - memory counts as programmed only when byte zero reads A5
`timescale 1ns/100ps
module eeprom_cmd_ctrl
  import eeprom_ctrl_pkg::*;
#(
  parameter int TIMEOUT_CYC = TIMEOUT_CYCLES
) (
  input  wire logic              clk,
  input  wire logic              rst_b,
  input  wire logic              clk_en,
  input  wire logic              link_clk,
  input  wire logic [CMD_W-1:0]  command_code_field,
  input  wire logic [ADDR_W-1:0] target_location_field,
  input  wire logic              busy_set,
  input  wire logic [DATA_W-1:0] data_wr_value,
  input  wire logic              data_wr_load,
  input  wire logic              timeout_clr,
  input  wire logic              serial_data_in,
  output logic                   op_in_progress_flag,
  output logic                   op_timeout_flag,
  output logic                   data_loaded_flag,
  output logic      [DATA_W-1:0] eeprom_data_reg,
  output logic                   serial_mem_clock,
  output logic                   serial_chip_select,
  output logic                   serial_data_out
);

  localparam int TO_W = $clog2(TIMEOUT_CYC) + 1;

  typedef enum logic [1:0] {L_IDLE, L_SHIFT, L_GAP, L_POLL} link_state_e;

  // host-domain state
  logic              busy_r;
  logic              to_flag_r;
  logic              loaded_r;
  logic [DATA_W-1:0] data_r;
  logic [CMD_W-1:0]  cmd_r;
  logic [ADDR_W-1:0] addr_r;
  logic [TO_W-1:0]   to_cnt_r;
  logic              start_tgl_r;
  logic              abort_tgl_r;
  logic              done_seen_r;
  logic              done_sync;
  logic              link_idle;
  logic              launch;
  logic              done_evt;
  logic              timeout_hit;

  // link-domain state
  link_state_e       state_r;
  logic              phase_r;
  logic [CYC_W-1:0]  cyc_left_r;
  logic [CYC_W-1:0]  cycles_r;
  logic [CYC_W-1:0]  edges_r;
  logic [FRAME_W-1:0] frame_r;
  logic [DATA_W-1:0] rd_shift_r;
  logic [DATA_W-1:0] rd_byte_r;
  logic              poll_r;
  logic [1:0]        tail_r;
  logic              sclk_r;
  logic              cs_r;
  logic              do_r;
  logic              done_tgl_r;
  logic              start_seen_r;
  logic              abort_seen_r;
  logic              start_sync;
  logic              abort_sync;
  logic              ce_l;
  logic              di_s;
  logic              new_start;
  logic              abort_req;

  // crossings into the link domain; clock enable first so the rest can freeze
  sync_three #(.W(1)) u_ce_sync (
    .clk   (link_clk),
    .rst_b (rst_b),
    .en    (1'b1),
    .d     (clk_en),
    .q     (ce_l)
  );

  sync_three #(.W(3)) u_link_sync (
    .clk   (link_clk),
    .rst_b (rst_b),
    .en    (ce_l),
    .d     ({start_tgl_r, abort_tgl_r, serial_data_in}),
    .q     ({start_sync, abort_sync, di_s})
  );

  // completion toggle back into the host domain
  sync_three #(.W(1)) u_done_sync (
    .clk   (clk),
    .rst_b (rst_b),
    .en    (clk_en),
    .d     (done_tgl_r),
    .q     (done_sync)
  );

  // the engine is idle once every start has been answered
  assign link_idle   = (done_seen_r == start_tgl_r);
  assign launch      = clk_en && busy_set && !busy_r && link_idle;
  assign done_evt    = clk_en && (done_sync != done_seen_r);
  assign timeout_hit = clk_en && busy_r && !done_evt && (to_cnt_r == TO_W'(TIMEOUT_CYC - 1));

  // command capture; held steady for the engine while busy
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cmd_r  <= CMD_READ;
      addr_r <= RELOAD_ADDR;
    end else if (launch) begin
      cmd_r  <= command_code_field;
      addr_r <= target_location_field;
    end
  end

  // start and abort toggles, completion bookkeeping
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      start_tgl_r <= 1'b0;
      abort_tgl_r <= 1'b0;
      done_seen_r <= 1'b0;
    end else if (clk_en) begin
      if (launch) begin
        start_tgl_r <= !start_tgl_r;
      end
      if (timeout_hit) begin
        abort_tgl_r <= !abort_tgl_r;
      end
      if (done_evt) begin
        done_seen_r <= done_sync;
      end
    end
  end

  // busy: set by host launch, cleared on completion or timeout
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      busy_r <= 1'b0;
    end else if (launch) begin
      busy_r <= 1'b1;
    end else if (busy_r && (done_evt || timeout_hit)) begin
      busy_r <= 1'b0;
    end
  end

  // timeout counter runs only while a command is outstanding
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      to_cnt_r <= '0;
    end else if (clk_en) begin
      if (launch || !busy_r) begin
        to_cnt_r <= '0;
      end else begin
        to_cnt_r <= to_cnt_r + TO_W'(1);
      end
    end
  end

  // timeout flag; a timeout in the clearing cycle wins over the clear
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      to_flag_r <= 1'b0;
    end else if (timeout_hit) begin
      to_flag_r <= 1'b1;
    end else if (clk_en && timeout_clr) begin
      to_flag_r <= 1'b0;
    end
  end

  // data register: host load when idle, read result on completion
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      data_r <= '0;
    end else if (busy_r && done_evt && (cmd_r == CMD_READ)) begin
      data_r <= rd_byte_r;
    end else if (clk_en && data_wr_load && !busy_r) begin
      data_r <= data_wr_value;
    end
  end

  // data-loaded flag: cleared when a reload starts, set only on the mark
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      loaded_r <= 1'b0;
    end else if (launch && (command_code_field == CMD_RELOAD)) begin
      loaded_r <= 1'b0;
    end else if (busy_r && done_evt && (cmd_r == CMD_RELOAD)) begin
      loaded_r <= (rd_byte_r == PROGRAMMED_MARK);
    end
  end

  assign op_in_progress_flag = busy_r;
  assign op_timeout_flag     = to_flag_r;
  assign data_loaded_flag    = loaded_r;
  assign eeprom_data_reg     = data_r;

  // link side: request detection
  assign new_start = (start_sync != start_seen_r);
  assign abort_req = (abort_sync != abort_seen_r);

  always_ff @(posedge link_clk or negedge rst_b) begin
    if (!rst_b) begin
      start_seen_r <= 1'b0;
      abort_seen_r <= 1'b0;
    end else if (ce_l) begin
      abort_seen_r <= abort_sync;
      if (state_r == L_IDLE) begin
        start_seen_r <= start_sync;
      end
    end
  end

  // serial engine: each serial clock is one low and one high link phase
  always_ff @(posedge link_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r    <= L_IDLE;
      phase_r    <= 1'b0;
      cyc_left_r <= '0;
      cycles_r   <= '0;
      frame_r    <= '0;
      rd_shift_r <= '0;
      rd_byte_r  <= '0;
      poll_r     <= 1'b0;
      tail_r     <= '0;
      sclk_r     <= 1'b0;
      cs_r       <= 1'b0;
      do_r       <= 1'b0;
      done_tgl_r <= 1'b0;
    end else if (ce_l) begin
      if (abort_req && (state_r != L_IDLE)) begin
        // abandoned by the host side; still answer so the handshake stays paired
        state_r    <= L_IDLE;
        sclk_r     <= 1'b0;
        cs_r       <= 1'b0;
        do_r       <= 1'b0;
        done_tgl_r <= !done_tgl_r;
      end else begin
        case (state_r)
          L_IDLE: begin
            if (new_start) begin
              // fields are stable: they were latched in the same cycle as the start toggle
              frame_r    <= {lead_field(cmd_r, addr_r), data_r};
              cycles_r   <= serial_cycles(cmd_r);
              cyc_left_r <= serial_cycles(cmd_r);
              poll_r     <= needs_ready(cmd_r);
              phase_r    <= 1'b0;
              tail_r     <= SAMPLE_LAG;
              cs_r       <= 1'b1;
              state_r    <= L_SHIFT;
            end
          end
          L_SHIFT: begin
            if (!phase_r) begin
              sclk_r  <= 1'b0;
              do_r    <= frame_r[FRAME_W-1];
              phase_r <= 1'b1;
            end else begin
              sclk_r     <= 1'b1;
              rd_shift_r <= {rd_shift_r[DATA_W-2:0], di_s};
              frame_r    <= {frame_r[FRAME_W-2:0], 1'b0};
              cyc_left_r <= cyc_left_r - CYC_W'(1);
              phase_r    <= 1'b0;
              if (cyc_left_r == CYC_W'(1)) begin
                state_r <= L_GAP;
              end
            end
          end
          L_GAP: begin
            // select held while the synchroniser delivers the last two bits
            sclk_r <= 1'b0;
            do_r   <= 1'b0;
            if (tail_r == '0) begin
              cs_r      <= 1'b0;
              rd_byte_r <= rd_shift_r;
              if (poll_r) begin
                state_r <= L_POLL;
              end else begin
                done_tgl_r <= !done_tgl_r;
                state_r    <= L_IDLE;
              end
            end else begin
              phase_r <= !phase_r;
              if (phase_r) begin
                rd_shift_r <= {rd_shift_r[DATA_W-2:0], di_s};
                tail_r     <= tail_r - 2'h1;
              end
            end
          end
          L_POLL: begin
            // memory holds data-in low while busy; host-side timer bounds the wait
            cs_r <= 1'b1;
            if (cs_r && di_s) begin
              cs_r       <= 1'b0;
              done_tgl_r <= !done_tgl_r;
              state_r    <= L_IDLE;
            end
          end
          default: begin
            state_r <= L_IDLE;
          end
        endcase
      end
    end
  end

  assign serial_mem_clock   = sclk_r;
  assign serial_chip_select = cs_r;
  assign serial_data_out    = do_r;

  // helper: serial clock rising edges within the current frame
  always_ff @(posedge link_clk or negedge rst_b) begin
    if (!rst_b) begin
      edges_r <= '0;
    end else if (ce_l) begin
      if (state_r == L_IDLE) begin
        edges_r <= '0;
      end else if ((state_r == L_SHIFT) && phase_r) begin
        edges_r <= edges_r + CYC_W'(1);
      end
    end
  end

  // checks on the host side
  busy_start_a: assert property (@(posedge clk) disable iff (!rst_b)
    launch |=> busy_r && (cmd_r == $past(command_code_field)))
    else $error("busy not set by launch");

  busy_end_a: assert property (@(posedge clk) disable iff (!rst_b)
    (busy_r && done_evt) |=> !busy_r)
    else $error("busy not cleared at completion");

  read_result_a: assert property (@(posedge clk) disable iff (!rst_b)
    (busy_r && done_evt && (cmd_r == CMD_READ)) |=> (data_r == $past(rd_byte_r)) && !busy_r)
    else $error("read byte not in data register");

  timeout_set_a: assert property (@(posedge clk) disable iff (!rst_b)
    timeout_hit |=> to_flag_r && !busy_r)
    else $error("timeout did not set flag and clear busy");

  timeout_limit_a: assert property (@(posedge clk) disable iff (!rst_b)
    busy_r |-> (to_cnt_r < TO_W'(TIMEOUT_CYC)))
    else $error("timeout counter passed its limit");

  reload_fail_a: assert property (@(posedge clk) disable iff (!rst_b)
    (busy_r && done_evt && (cmd_r == CMD_RELOAD) && (rd_byte_r != PROGRAMMED_MARK)) |=> !loaded_r)
    else $error("reload passed without mark");

  reload_pass_a: assert property (@(posedge clk) disable iff (!rst_b)
    (busy_r && done_evt && (cmd_r == CMD_RELOAD) && (rd_byte_r == PROGRAMMED_MARK)) |=> loaded_r)
    else $error("data loaded not set");

  // checks on the link side
  clock_count_a: assert property (@(posedge link_clk) disable iff (!rst_b)
    (ce_l && (state_r == L_GAP)) |-> (edges_r == cycles_r))
    else $error("wrong number of serial clocks");

  frame_select_a: assert property (@(posedge link_clk) disable iff (!rst_b)
    (state_r == L_SHIFT) |-> cs_r)
    else $error("chip select dropped inside frame");

  start_bit_a: assert property (@(posedge link_clk) disable iff (!rst_b)
    (ce_l && (state_r == L_IDLE) && new_start && !abort_req) |=> ##1 (!ce_l || do_r || (state_r != L_SHIFT)))
    else $error("frame did not open with start bit");

endmodule : eeprom_cmd_ctrl

// ---- test/eeprom_model.sv ----
/*
  Behavioural 3-wire serial memory: 128 bytes, erased to FF, write-protected at power-up.
  Assumes frames arrive MSB first and that its data line has a pull-down on the board.
*/
`timescale 1ns/100ps
module eeprom_model (
  input  wire logic sclk,
  input  wire logic cs,
  input  wire logic din,
  input  wire logic absent,
  output logic      dout
);
  logic [7:0]  mem [128];
  logic [17:0] sh = 18'h00000;
  logic [7:0]  rdat = 8'h00;
  logic        wen = 1'b0; // protected until enabled
  logic        busy = 1'b0;
  logic        drv = 1'b0;
  logic        val = 1'b0;
  logic        rd = 1'b0;
  int          n = 0;

  // a released line falls to the pull-down; a missing part never drives
  assign dout = (drv && !absent) ? val : 1'b0;

  initial for (int i = 0; i < 128; i++) mem[i] = 8'hFF;

  // select shows ready status until the first clock of the frame
  always @(posedge cs) begin
    n = 0;
    drv = 1'b1;
    val = !busy;
  end

  // programming time over: status line goes ready while selected
  always @(negedge busy) val = 1'b1;

  // shift in command bits; long writes commit on the last bit
  always @(posedge sclk) if (cs) begin
    sh = {sh[16:0], din};
    n = n + 1;
    if (n == 1) drv = 1'b0;
    if (n == 10 && sh[8:7] == 2'h2) begin
      rd = 1'b1;
      rdat = mem[sh[6:0]];
    end
    if (n == 18 && wen && sh[16:15] == 2'h1) begin
      mem[sh[14:8]] = sh[7:0];
      busy = 1'b1;
      busy <= #2000 1'b0;
    end
    if (n == 18 && wen && sh[16:15] == 2'h0 && sh[14:13] == 2'h1) begin
      for (int i = 0; i < 128; i++) mem[i] = sh[7:0];
      busy = 1'b1;
      busy <= #2000 1'b0;
    end
  end

  // read data leaves while the clock is low so it is steady at the rising edge
  always @(negedge sclk) if (cs && rd && n >= 10 && n < 18) begin
    drv = 1'b1;
    val = rdat[17-n];
  end

  // short commands act on deselect; enable and disable gate all programming
  always @(negedge cs) begin
    drv = 1'b0;
    rd = 1'b0;
    if (n == 10 && sh[8:7] == 2'h0 && sh[6:5] == 2'h3) wen = 1'b1;
    if (n == 10 && sh[8:7] == 2'h0 && sh[6:5] == 2'h0) wen = 1'b0;
    if (n == 10 && wen && sh[8:7] == 2'h3) begin
      mem[sh[6:0]] = 8'hFF;
      busy = 1'b1;
      busy <= #2000 1'b0;
    end
    if (n == 10 && wen && sh[8:7] == 2'h0 && sh[6:5] == 2'h2) begin
      for (int i = 0; i < 128; i++) mem[i] = 8'hFF;
      busy = 1'b1;
      busy <= #2000 1'b0;
    end
  end
endmodule : eeprom_model

// ---- test/tb.sv ----
/*
  Self-checking bench for the serial memory command controller.
  Assumes eeprom_model on the link pins; host inputs change at the falling clock edge.
*/
`timescale 1ns/100ps
module tb;
  import eeprom_ctrl_pkg::*;
  localparam int TMO = 2000; // short timeout keeps the run brief
  logic              clk = 1'b0, link_clk = 1'b0, rst_b = 1'b0, clk_en = 1'b1;
  logic [CMD_W-1:0]  code = 3'h0;
  logic [ADDR_W-1:0] addr = 9'h000;
  logic [DATA_W-1:0] wval = 8'h00, dreg;
  logic              bset = 1'b0, wload = 1'b0, tclr = 1'b0, absent = 1'b0, di;
  logic              busy, tmo, loaded, sclk, cs, dout;
  int                num_errors = 0, checks = 0, sc = 0, span = 0;

  always #5 clk = ~clk;
  // link clock starts off phase with the system clock
  initial begin
    #17;
    forever #40 link_clk = ~link_clk;
  end
  // serial clock pulses of the current command
  always @(posedge sclk) sc = sc + 1;

  eeprom_cmd_ctrl #(.TIMEOUT_CYC(TMO)) uut (
    .clk(clk), .rst_b(rst_b), .clk_en(clk_en), .link_clk(link_clk), .command_code_field(code),
    .target_location_field(addr), .busy_set(bset), .data_wr_value(wval), .data_wr_load(wload),
    .timeout_clr(tclr), .serial_data_in(di), .op_in_progress_flag(busy), .op_timeout_flag(tmo),
    .data_loaded_flag(loaded), .eeprom_data_reg(dreg), .serial_mem_clock(sclk),
    .serial_chip_select(cs), .serial_data_out(dout));

  eeprom_model mem (.sclk(sclk), .cs(cs), .din(dout), .absent(absent), .dout(di));

  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic load(input logic [7:0] v);
    @(negedge clk) wval = v;
    wload = 1'b1;
    @(negedge clk) wload = 1'b0;
  endtask : load

  // launch one command and poll busy under a bound, then count serial clocks
  task automatic cmd(input logic [2:0] c, input logic [8:0] a, input int ncyc);
    @(negedge clk) code = c;
    addr = a;
    bset = 1'b1;
    sc = 0;
    @(negedge clk) bset = 1'b0;
    chk("busy set", 8'h01, {7'h00, busy});
    span = 0;
    // command inputs stay put until busy reads zero
    while (busy !== 1'b0 && span < TMO + 50) begin
      @(negedge clk);
      span++;
    end
    chk("busy clear", 8'h00, {7'h00, busy});
    chk("serial clocks", ncyc[7:0], sc[7:0]);
    repeat (8) @(negedge clk);
  endtask : cmd

  task automatic t_protect;
    load(8'h3C);
    cmd(CMD_WRITE, 9'h005, 18);
    cmd(CMD_READ, 9'h005, 18);
    chk("write while protected", 8'hFF, dreg);
    $display("done: protect");
  endtask : t_protect

  // a load during the read is refused, so the fetched byte must win
  task automatic t_write_read;
    cmd(CMD_WR_ON, 9'h000, 10);
    load(8'h3C);
    cmd(CMD_WRITE, 9'h005, 18);
    fork
      cmd(CMD_READ, 9'h005, 18);
      begin
        repeat (30) @(negedge clk);
        load(8'hDD);
      end
    join
    chk("read back", 8'h3C, dreg);
    $display("done: write_read");
  endtask : t_write_read

  task automatic t_erase_all;
    cmd(CMD_ERASE, 9'h005, 10);
    cmd(CMD_READ, 9'h005, 18);
    chk("erased byte", 8'hFF, dreg);
    load(8'h5A);
    cmd(CMD_FILL, 9'h000, 18);
    cmd(CMD_READ, 9'h07F, 18);
    chk("written everywhere", 8'h5A, dreg);
    cmd(CMD_WIPE, 9'h000, 10);
    cmd(CMD_READ, 9'h011, 18);
    chk("erased everywhere", 8'hFF, dreg);
    cmd(CMD_WR_OFF, 9'h000, 10);
    load(8'h77);
    cmd(CMD_WRITE, 9'h009, 18);
    cmd(CMD_READ, 9'h009, 18);
    chk("write after disable", 8'hFF, dreg);
    $display("done: erase_all");
  endtask : t_erase_all

  // reload is exercised here only; normal use would take a soft reset
  task automatic t_reload;
    cmd(CMD_RELOAD, 9'h000, 18);
    chk("reload of blank part", 8'h00, {7'h00, loaded});
    cmd(CMD_WR_ON, 9'h000, 10);
    load(8'hA5);
    cmd(CMD_WRITE, 9'h000, 18);
    cmd(CMD_RELOAD, 9'h000, 18);
    chk("reload of marked part", 8'h01, {7'h00, loaded});
    $display("done: reload");
  endtask : t_reload

  // a missing part never reports ready, so the write must be abandoned
  task automatic t_timeout;
    absent = 1'b1;
    cmd(CMD_WRITE, 9'h001, 18);
    chk("timeout flag", 8'h01, {7'h00, tmo});
    chk("timeout span", 8'h01, {7'h00, (span >= TMO - 6 && span <= TMO)});
    @(negedge clk) tclr = 1'b1;
    @(negedge clk) tclr = 1'b0;
    chk("timeout cleared", 8'h00, {7'h00, tmo});
    absent = 1'b0;
    repeat (100) @(negedge clk);
    cmd(CMD_READ, 9'h000, 18);
    chk("read after abort", 8'hA5, dreg);
    $display("done: timeout");
  endtask : t_timeout

  task automatic t_freeze;
    clk_en = 1'b0;
    @(negedge clk) bset = 1'b1;
    @(negedge clk) bset = 1'b0;
    @(negedge clk) chk("start while frozen", 8'h00, {7'h00, busy});
    clk_en = 1'b1;
    $display("done: freeze");
  endtask : t_freeze

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : wrap_up

  // run takes well under 300 us; 3 ms means a hang
  initial begin
    #3000000;
    num_errors++;
    wrap_up();
  end

  initial begin
    repeat (16) @(negedge clk);
    rst_b = 1'b1;
    chk("flags after reset", 8'h00, {5'h00, busy, tmo, loaded});
    chk("data after reset", 8'h00, dreg);
    repeat (10) @(negedge clk); // first command only after the reset-time phase
    t_protect();
    t_write_read();
    t_erase_all();
    t_reload();
    t_timeout();
    t_freeze();
    wrap_up();
  end
endmodule : tb
